// >>> bench/dmr_ctrl_model.sv
/*
 * dmr_ctrl_model: controller side issuing mode register writes and reads.
 * Assumes the register slice samples strobes on the rising edge of clk_sys_i.
 */
`timescale 1ns/100ps
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input wire logic clk_sys_i,
    output logic mr_wr_o,
    output logic mr_rd_o,
    output logic [DMR_ADDR_W-1:0] mr_addr_o,
    output logic [DMR_DATA_W-1:0] mr_wdata_o,
    input wire logic [DMR_DATA_W-1:0] mr_rdata_i,
    input wire logic mr_rvalid_i
);
    initial begin
        mr_wr_o = 1'b0;
        mr_rd_o = 1'b0;
        mr_addr_o = 6'h15;
        mr_wdata_o = 8'ha5;
    end

    // released bus shows the inverse, so a stale value is never taken as valid
    task automatic idle();
        mr_wr_o = 1'b0;
        mr_rd_o = 1'b0;
        mr_addr_o = ~mr_addr_o;
        mr_wdata_o = ~mr_wdata_o;
    endtask : idle

    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        mr_wr_o = 1'b1;
        mr_addr_o = a;
        // test register only ever receives zero
        mr_wdata_o = (a == DMR_ADDR_TEST) ? 8'h00 : d;
        @(negedge clk_sys_i);
        idle();
    endtask : mrw

    task automatic mrr(input logic [5:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys_i);
        mr_rd_o = 1'b1;
        mr_addr_o = a;
        @(negedge clk_sys_i);
        d = mr_rdata_i;
        v = mr_rvalid_i;
        idle();
    endtask : mrr
endmodule : dmr_ctrl_model

// >>> bench/dmr_mode_regs_6_to_12_tb.sv
/*
 * dmr_mode_regs_6_to_12_tb: self-checking bench for the mode register slice.
 * Assumes dmr_pkg and the controller model are compiled first.
 */
`timescale 1ns/100ps
module dmr_mode_regs_6_to_12_tb;
    import dmr_pkg::*;
    localparam logic [7:0] P_REV1 = 8'h5a; // arbitrary value
    localparam logic [7:0] P_REV2 = 8'hc3; // arbitrary value
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cal_cmd_i = 1'b0;
    logic cal_pin_resistor_i = 1'b1;
    logic mr_wr, mr_rd, mr_rvalid, test_mode, cal_rst, cal_start, vref_rng, op_sel;
    logic [5:0] mr_addr, vref;
    logic [7:0] mr_wdata, mr_rdata, rd;
    logic [2:0] dq_term, ca_term;
    int bad_count = 0;
    int n_checks = 0;

    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    dmr_mode_regs #(.REV_ONE(P_REV1), .REV_TWO(P_REV2), .DENSITY(4'hc), .IO_WIDTH(DMR_WIDTH_X8)) i_dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mr_wr_i(mr_wr), .mr_rd_i(mr_rd),
        .mr_addr_i(mr_addr), .mr_wdata_i(mr_wdata), .cal_cmd_i(cal_cmd_i),
        .cal_pin_resistor_i(cal_pin_resistor_i), .mr_rdata_o(mr_rdata), .mr_rvalid_o(mr_rvalid),
        .test_mode_o(test_mode), .cal_default_reset_o(cal_rst), .cal_start_o(cal_start),
        .data_lane_termination_o(dq_term), .cmdaddr_termination_o(ca_term), .cmdaddr_vref_o(vref),
        .cmdaddr_vref_range_o(vref_rng), .setpoint_operating_select_o(op_sel));

    dmr_ctrl_model i_ctrl (.clk_sys_i(clk_sys_i), .mr_wr_o(mr_wr), .mr_rd_o(mr_rd), .mr_addr_o(mr_addr),
        .mr_wdata_o(mr_wdata), .mr_rdata_i(mr_rdata), .mr_rvalid_i(mr_rvalid));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // read and check both the data and the valid strobe
    task automatic rchk(input string name, input logic [5:0] a, input logic [7:0] exp);
        logic v;
        i_ctrl.mrr(a, rd, v);
        chk({name, " valid"}, {7'h0, v}, 8'h01);
        chk(name, rd, exp);
    endtask : rchk

    task automatic t_ident();
        rchk("rev one", DMR_ADDR_REV_ONE, P_REV1);
        rchk("rev two", DMR_ADDR_REV_TWO, P_REV2);
        i_ctrl.mrw(DMR_ADDR_DIE_CFG, 8'hff);
        i_ctrl.mrw(DMR_ADDR_REV_ONE, ~P_REV1);
        rchk("die cfg", DMR_ADDR_DIE_CFG, 8'h70);
        rchk("rev kept", DMR_ADDR_REV_ONE, P_REV1);
        i_ctrl.mrw(DMR_ADDR_TEST, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        chk("test mode", {7'h0, test_mode}, 8'h00);
        rchk("test read", DMR_ADDR_TEST, 8'h00);
        $display("test ident done");
    endtask : t_ident

    task automatic t_term();
        chk("op sel rst", {7'h0, op_sel}, 8'h00);
        i_ctrl.mrw(DMR_ADDR_TERM, 8'h25);
        i_ctrl.mrw(DMR_ADDR_SETPOINT, 8'h40);
        i_ctrl.mrw(DMR_ADDR_TERM, 8'hff);
        rchk("term sp1", DMR_ADDR_TERM, 8'h77);
        i_ctrl.mrw(DMR_ADDR_TERM, 8'h63);
        rchk("term sp1 b", DMR_ADDR_TERM, 8'h63);
        repeat (3) @(negedge clk_sys_i);
        chk("dq sp0", {5'h0, dq_term}, 8'h05);
        chk("ca sp0", {5'h0, ca_term}, 8'h02);
        i_ctrl.mrw(DMR_ADDR_SETPOINT, 8'h80);
        rchk("term sp0", DMR_ADDR_TERM, 8'h25);
        repeat (3) @(negedge clk_sys_i);
        chk("op sel", {7'h0, op_sel}, 8'h01);
        chk("dq sp1", {5'h0, dq_term}, 8'h03);
        chk("ca sp1", {5'h0, ca_term}, 8'h06);
        i_ctrl.mrw(DMR_ADDR_TERM, 8'h77);
        repeat (3) @(negedge clk_sys_i);
        chk("dq kept", {5'h0, dq_term}, 8'h03);
        chk("ca kept", {5'h0, ca_term}, 8'h06);
        i_ctrl.mrw(DMR_ADDR_SETPOINT, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        chk("dq rsvd", {5'h0, dq_term}, 8'h00);
        chk("ca rsvd", {5'h0, ca_term}, 8'h00);
        $display("test term done");
    endtask : t_term

    task automatic t_vref();
        rchk("vref rst", DMR_ADDR_VREF, DMR_VREF_RST);
        chk("vref rng rst", {7'h0, vref_rng}, 8'h01);
        i_ctrl.mrw(DMR_ADDR_SETPOINT, 8'hc0);
        i_ctrl.mrw(DMR_ADDR_VREF, 8'hab);
        i_ctrl.mrw(DMR_ADDR_TERM, 8'h12);
        rchk("vref", DMR_ADDR_VREF, 8'h2b);
        repeat (3) @(negedge clk_sys_i);
        chk("vref out", {2'h0, vref}, 8'h2b);
        chk("vref rng", {7'h0, vref_rng}, 8'h00);
        chk("dq sp1 new", {5'h0, dq_term}, 8'h02);
        chk("ca sp1 new", {5'h0, ca_term}, 8'h01);
        // inactive copy rewritten while set point 1 operates
        i_ctrl.mrw(DMR_ADDR_SETPOINT, 8'h80);
        i_ctrl.mrw(DMR_ADDR_VREF, 8'h15);
        rchk("vref sp0", DMR_ADDR_VREF, 8'h15);
        repeat (3) @(negedge clk_sys_i);
        chk("vref kept", {2'h0, vref}, 8'h2b);
        $display("test vref done");
    endtask : t_vref

    task automatic t_cal(input logic strap, input logic [7:0] exp);
        cal_pin_resistor_i = strap;
        repeat (4) @(negedge clk_sys_i);
        cal_cmd_i = 1'b1;
        @(negedge clk_sys_i);
        cal_cmd_i = 1'b0;
        chk("cal start", {7'h0, cal_start}, exp);
        @(negedge clk_sys_i);
        chk("cal start end", {7'h0, cal_start}, 8'h00);
        i_ctrl.mrw(DMR_ADDR_CAL_RST, 8'h01);
        chk("cal reset", {7'h0, cal_rst}, 8'h01);
        @(negedge clk_sys_i);
        chk("cal reset end", {7'h0, cal_rst}, 8'h00);
        $display("test cal done");
    endtask : t_cal

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (8) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        t_ident();
        t_term();
        t_vref();
        t_cal(1'b1, 8'h01);
        t_cal(1'b0, 8'h00);
        wrap_up();
    end
endmodule : dmr_mode_regs_6_to_12_tb

// >>> rtl/dmr_mode_regs.sv
/*
 * dmr_mode_regs: mode registers 06h..0Ch of the memory die, plus the two
 * set-point select bits of register 0Dh needed to steer them.
 * Assumes decoded mode-register write/read strobes from the command decoder
 * on clk_sys_i, and the calibration pin strap from the package.
 */
// Functional notes
// - register 06h returns first revision code
// - register 07h returns second revision code
// - register 08h bits 1:0 report 00b
// - register 08h bits 5:2 report die density
// - register 08h bits 7:6 report I/O width
// - 09h test mode disabled when zero
// - 0Ah bit0 triggers default calibration reset
// - calibration pin grounded: ignore calibration commands
// - resistor-tied pin: both calibration kinds allowed
// - 0Bh bits 2:0 data-lane termination code
// - 0Bh bits 6:4 cmdaddr termination code
// - termination duplicated, access select picks copy
// - operating select copy drives device behaviour
// - 0Ch holds vref bits 5:0, range 6
// - both selects default to set point 0
// - reads put data on lanes, reserved zero
`timescale 1ns/100ps
module dmr_mode_regs
    import dmr_pkg::*;
#(
    parameter logic [7:0] REV_ONE = DMR_REV_ONE_DEF, // arbitrary value
    parameter logic [7:0] REV_TWO = DMR_REV_TWO_DEF, // arbitrary value
    parameter logic [3:0] DENSITY = DMR_DENS_4G,
    parameter logic [1:0] IO_WIDTH = DMR_WIDTH_X16
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic mr_wr_i,
    input wire logic mr_rd_i,
    input wire logic [DMR_ADDR_W-1:0] mr_addr_i,
    input wire logic [DMR_DATA_W-1:0] mr_wdata_i,
    input wire logic cal_cmd_i,
    input wire logic cal_pin_resistor_i,
    output logic [DMR_DATA_W-1:0] mr_rdata_o,
    output logic mr_rvalid_o,
    output logic test_mode_o,
    output logic cal_default_reset_o,
    output logic cal_start_o,
    output logic [2:0] data_lane_termination_o,
    output logic [2:0] cmdaddr_termination_o,
    output logic [5:0] cmdaddr_vref_o,
    output logic cmdaddr_vref_range_o,
    output logic setpoint_operating_select_o
);
    logic strap_meta_ff;
    logic strap_sync_ff;
    logic setpoint_access_select_ff;
    logic setpoint_operating_select_ff;
    logic [7:0] test_ff;
    logic [7:0] term_acc;
    logic [7:0] term_op;
    logic [7:0] vref_acc;
    logic [7:0] vref_op;
    logic [7:0] nxt_rdata;
    logic wr_term;
    logic wr_vref;
    logic [7:0] die_cfg;

    // strap comes from a pin; synchronise before use
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= cal_pin_resistor_i;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // set-point selects live in register 0Dh, only bits 7:6 kept here
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            setpoint_access_select_ff <= 1'b0;
            setpoint_operating_select_ff <= 1'b0;
        end else if (mr_wr_i && mr_addr_i == DMR_ADDR_SETPOINT) begin
            setpoint_access_select_ff <= mr_wdata_i[DMR_ACCESS_SEL_BIT];
            setpoint_operating_select_ff <= mr_wdata_i[DMR_OPER_SEL_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            test_ff <= DMR_TEST_RST;
        end else if (mr_wr_i && mr_addr_i == DMR_ADDR_TEST) begin
            test_ff <= mr_wdata_i;
        end
    end

    // test mode only engages on a nonzero value
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            test_mode_o <= 1'b0;
        end else begin
            test_mode_o <= (test_ff != DMR_TEST_RST);
        end
    end

    // calibration reset is self-clearing: a one-cycle pulse per write of 1b
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cal_default_reset_o <= 1'b0;
        end else begin
            cal_default_reset_o <= mr_wr_i && mr_addr_i == DMR_ADDR_CAL_RST
                && mr_wdata_i[DMR_CAL_RST_BIT];
        end
    end

    // grounded pin: commanded calibration dropped
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cal_start_o <= 1'b0;
        end else begin
            cal_start_o <= cal_cmd_i && strap_sync_ff;
        end
    end

    assign wr_term = mr_wr_i && mr_addr_i == DMR_ADDR_TERM;
    assign wr_vref = mr_wr_i && mr_addr_i == DMR_ADDR_VREF;

    // reserved bits 7 and 3 stored as zero
    dmr_setpoint_copy #(
        .RST_VAL(8'h00),
        .WR_MASK(8'h77)
    ) u_term (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_term),
        .wdata_i(mr_wdata_i),
        .access_sel_i(setpoint_access_select_ff),
        .oper_sel_i(setpoint_operating_select_ff),
        .access_val_o(term_acc),
        .oper_val_o(term_op)
    );

    dmr_setpoint_copy #(
        .RST_VAL(DMR_VREF_RST),
        .WR_MASK(DMR_VREF_MASK)
    ) u_vref (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_vref),
        .wdata_i(mr_wdata_i),
        .access_sel_i(setpoint_access_select_ff),
        .oper_sel_i(setpoint_operating_select_ff),
        .access_val_o(vref_acc),
        .oper_val_o(vref_op)
    );

    // reserved code 111b treated as off rather than an undefined strength
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            data_lane_termination_o <= DMR_TERM_OFF;
            cmdaddr_termination_o <= DMR_TERM_OFF;
        end else begin
            data_lane_termination_o <= (term_op[DMR_DQ_TERM_LSB+:3] == DMR_TERM_RSVD) ? DMR_TERM_OFF
                : term_op[DMR_DQ_TERM_LSB+:3];
            cmdaddr_termination_o <= (term_op[DMR_CA_TERM_LSB+:3] == DMR_TERM_RSVD) ? DMR_TERM_OFF
                : term_op[DMR_CA_TERM_LSB+:3];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cmdaddr_vref_o <= DMR_VREF_RST[5:0];
            cmdaddr_vref_range_o <= DMR_VREF_RST[DMR_VREF_RANGE_BIT];
            setpoint_operating_select_o <= 1'b0;
        end else begin
            cmdaddr_vref_o <= vref_op[5:0];
            cmdaddr_vref_range_o <= vref_op[DMR_VREF_RANGE_BIT];
            setpoint_operating_select_o <= setpoint_operating_select_ff;
        end
    end

    // identification is constant; no write path exists
    assign die_cfg = {IO_WIDTH, DENSITY, DMR_TYPE_SIXTEEN_PREFETCH};

    always_comb begin
        nxt_rdata = 8'h00;
        unique case (mr_addr_i)
            DMR_ADDR_REV_ONE: nxt_rdata = REV_ONE;
            DMR_ADDR_REV_TWO: nxt_rdata = REV_TWO;
            DMR_ADDR_DIE_CFG: nxt_rdata = die_cfg;
            DMR_ADDR_TERM: nxt_rdata = term_acc;
            DMR_ADDR_VREF: nxt_rdata = vref_acc;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mr_rdata_o <= 8'h00;
            mr_rvalid_o <= 1'b0;
        end else begin
            mr_rvalid_o <= mr_rd_i;
            mr_rdata_o <= mr_rd_i ? nxt_rdata : 8'h00;
        end
    end

    property p_rd_cfg;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_rd_i && mr_addr_i == DMR_ADDR_DIE_CFG |=> mr_rdata_o == die_cfg && mr_rvalid_o;
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("die config read wrong");

    property p_rd_rev;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_rd_i && mr_addr_i == DMR_ADDR_REV_ONE |=> mr_rdata_o == REV_ONE;
    endproperty
    a_rd_rev: assert property (p_rd_rev) else $error("revision read wrong");

    property p_rd_rev2;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_rd_i && mr_addr_i == DMR_ADDR_REV_TWO |=> mr_rdata_o == REV_TWO && mr_rvalid_o;
    endproperty
    a_rd_rev2: assert property (p_rd_rev2) else $error("second revision read wrong");

    // write-only registers have no read path
    property p_rd_wo;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_rd_i && (mr_addr_i == DMR_ADDR_TEST || mr_addr_i == DMR_ADDR_CAL_RST)
            |=> mr_rdata_o == 8'h00 && mr_rvalid_o;
    endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");

    property p_rd_vref_rsvd;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_rd_i && mr_addr_i == DMR_ADDR_VREF |=> !mr_rdata_o[7] && mr_rvalid_o;
    endproperty
    a_rd_vref_rsvd: assert property (p_rd_vref_rsvd) else $error("vref reserved bit set");

    property p_rd_idle;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !mr_rd_i |=> mr_rdata_o == 8'h00 && !mr_rvalid_o;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read lanes not zero");

    property p_cal_rst;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_wr_i && mr_addr_i == DMR_ADDR_CAL_RST && mr_wdata_i[DMR_CAL_RST_BIT] |=> cal_default_reset_o;
    endproperty
    a_cal_rst: assert property (p_cal_rst) else $error("calibration reset pulse wrong");

    // back-to-back writes may hold the pulse, anything else must drop it
    property p_cal_end;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !(mr_wr_i && mr_addr_i == DMR_ADDR_CAL_RST && mr_wdata_i[DMR_CAL_RST_BIT]) |=> !cal_default_reset_o;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration reset without write");

    property p_cal_gnd;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !strap_sync_ff |=> !cal_start_o;
    endproperty
    a_cal_gnd: assert property (p_cal_gnd) else $error("calibration not ignored");

    sequence s_term_wr;
        wr_term && !mr_wdata_i[2] && mr_wdata_i[2:0] != 3'h0 && setpoint_access_select_ff == setpoint_operating_select_ff;
    endsequence
    property p_term_op;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_term_wr |-> ##2 data_lane_termination_o == $past(mr_wdata_i[2:0], 2);
    endproperty
    a_term_op: assert property (p_term_op) else $error("termination not applied");

    property p_term_rsvd;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        data_lane_termination_o != DMR_TERM_RSVD && cmdaddr_termination_o != DMR_TERM_RSVD;
    endproperty
    a_term_rsvd: assert property (p_term_rsvd) else $error("reserved termination applied");

    property p_sel_follow;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_wr_i && mr_addr_i == DMR_ADDR_SETPOINT
            |-> ##2 setpoint_operating_select_o == $past(mr_wdata_i[DMR_OPER_SEL_BIT], 2);
    endproperty
    a_sel_follow: assert property (p_sel_follow) else $error("operating select not taken");

    property p_inactive;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_vref && setpoint_access_select_ff != setpoint_operating_select_ff |=> $stable(vref_op);
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive copy disturbed");

    property p_test;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_wr_i && mr_addr_i == DMR_ADDR_TEST && mr_wdata_i != 8'h00 |-> ##2 test_mode_o;
    endproperty
    a_test: assert property (p_test) else $error("test mode not entered");

    property p_test_zero;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        mr_wr_i && mr_addr_i == DMR_ADDR_TEST && mr_wdata_i == 8'h00 |-> ##2 !test_mode_o;
    endproperty
    a_test_zero: assert property (p_test_zero) else $error("test mode not left");
endmodule : dmr_mode_regs

// >>> rtl/dmr_pkg.sv
/*
 * dmr_pkg: constants for the mode register slice at addresses 06h..0Ch.
 * Assumes a 6-bit mode register address and 8-bit operand as on the command bus.
 */
package dmr_pkg;
    localparam int DMR_ADDR_W = 6;
    localparam int DMR_DATA_W = 8;
    localparam logic [5:0] DMR_ADDR_REV_ONE = 6'h06;
    localparam logic [5:0] DMR_ADDR_REV_TWO = 6'h07;
    localparam logic [5:0] DMR_ADDR_DIE_CFG = 6'h08;
    localparam logic [5:0] DMR_ADDR_TEST = 6'h09;
    localparam logic [5:0] DMR_ADDR_CAL_RST = 6'h0a;
    localparam logic [5:0] DMR_ADDR_TERM = 6'h0b;
    localparam logic [5:0] DMR_ADDR_VREF = 6'h0c;
    localparam logic [5:0] DMR_ADDR_SETPOINT = 6'h0d;
    // field positions
    localparam int DMR_TYPE_LSB = 0;
    localparam int DMR_DENS_LSB = 2;
    localparam int DMR_WIDTH_LSB = 6;
    localparam int DMR_CAL_RST_BIT = 0;
    localparam int DMR_DQ_TERM_LSB = 0;
    localparam int DMR_CA_TERM_LSB = 4;
    localparam int DMR_VREF_RANGE_BIT = 6;
    localparam int DMR_ACCESS_SEL_BIT = 6;
    localparam int DMR_OPER_SEL_BIT = 7;
    // codes and reset values
    localparam logic [1:0] DMR_TYPE_SIXTEEN_PREFETCH = 2'h0;
    localparam logic [1:0] DMR_WIDTH_X16 = 2'h0;
    localparam logic [1:0] DMR_WIDTH_X8 = 2'h1;
    localparam logic [3:0] DMR_DENS_4G = 4'h0;
    localparam logic [2:0] DMR_TERM_OFF = 3'h0;
    localparam logic [2:0] DMR_TERM_RSVD = 3'h7;
    localparam logic [7:0] DMR_TEST_RST = 8'h00;
    localparam logic [7:0] DMR_VREF_RST = 8'h40;
    localparam logic [7:0] DMR_VREF_MASK = 8'h7f;
    localparam logic [7:0] DMR_REV_ONE_DEF = 8'h00;
    localparam logic [7:0] DMR_REV_TWO_DEF = 8'h00;
endpackage : dmr_pkg

// >>> rtl/dmr_setpoint_copy.sv
/*
 * dmr_setpoint_copy: one 8-bit register held twice, once per set point.
 * Assumes caller supplies access and operating selects on the same clock.
 */
`timescale 1ns/100ps
module dmr_setpoint_copy #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic access_sel_i,
    input wire logic oper_sel_i,
    output logic [7:0] access_val_o,
    output logic [7:0] oper_val_o
);
    logic [7:0] copy_ff [2];

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            copy_ff[0] <= RST_VAL;
            copy_ff[1] <= RST_VAL;
        end else if (wr_i) begin
            copy_ff[access_sel_i] <= wdata_i & WR_MASK;
        end
    end

    assign access_val_o = copy_ff[access_sel_i];
    assign oper_val_o = copy_ff[oper_sel_i];
endmodule : dmr_setpoint_copy
